// file: rtl/vic_capture.sv
// Capture end: samples link, de-skews, pairs words, AHB registers
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - 1X clock: capture on both edges
// - 2X clock: capture on one edge
// - SDR latch edge chosen by software
// - DDR first-word edge chosen by software
// - Rising means true clock rises
// - De-skew moves sampling, not the clock
// - Four-bit code, signed step offset
// - Code held in register 1Dh bits 3:0
// - Three-bit format, two words per pixel
// - Format 0 twelve-bit RGB scheme one
// - Format 1 twelve-bit RGB scheme two
// - Format 2 RGB 565 on upper byte
// - Format 3 RGB 555, second-word bit 11 ignored
// - Format 4 Cb Y Cr Y order
// - First word follows hsync leading edge
// - Source blanks idle pixels
// - Reference is ff, 00, 00, status
// - Status bit 6 is field
// - Status bit 5 is vertical blank
// - Status bit 4 is EAV versus SAV
// - Status bits 7, 3:0 ignored
// - Decode only when sync enable set
module vic_capture
#(
	parameter int DLY_MAX = 8
)
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        CE,
	vic_link_if.cap          link,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             PIX_VLD,
	output logic [23:0]      PIX_DATA,
	output logic             REF_PULSE
);
	// ************************************************************
	// Registers
	// ************************************************************
	logic        ddr_q, pol_q, sync_en_q, wr_q;
	logic [2:0]  fmt_q;
	logic [3:0]  deskew_q;
	logic [7:0]  addr_q;
	logic [15:0] count_q;

	// AHB-Lite slave, zero wait, always OKAY
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			ddr_q <= 1'b0;
			pol_q <= 1'b0;
			fmt_q <= 3'h0;
			deskew_q <= vic_pkg::DESKEW_MID;
			sync_en_q <= 1'b0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else if (CE)
		begin
			if (wr_q)
			begin
				case (addr_q)
					vic_pkg::REG_CTRL:
					begin
						ddr_q <= HWDATA[vic_pkg::CTRL_DDR_BIT];
						pol_q <= HWDATA[vic_pkg::CTRL_POL_BIT];
						fmt_q <= HWDATA[vic_pkg::CTRL_FMT_LSB +: 3];
					end
					vic_pkg::REG_DESKEW: deskew_q <= HWDATA[3:0];
					vic_pkg::REG_SYNC:   sync_en_q <= HWDATA[vic_pkg::SYNC_EN_BIT];
					default: ;
				endcase
			end
			wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
			if (HSEL && HREADY && HTRANS[1])
				addr_q <= HADDR[7:0];
		end
	end

	// ************************************************************
	// Link sampling: two-flop sync, then de-skew delay line
	// ************************************************************
	logic [13:0] s1_q, s2_q;
	logic [13:0] dly_q [DLY_MAX*2+1];
	// Hsync rides with the clock so its edge lines up with the word edges
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			s1_q <= 14'h0000;
			s2_q <= 14'h0000;
		end
		else if (CE)
		begin
			s1_q <= {link.hsync, link.input_word_clock, link.bus};
			s2_q <= s1_q;
		end
	end

	// Data delayed, clock tap fixed at centre
	genvar gi;
	generate
		for (gi = 0; gi < DLY_MAX*2+1; gi++)
		begin : g_dly
			always_ff @(posedge CLK or negedge RSTN)
			begin
				if (!RSTN)
					dly_q[gi] <= 14'h0000;
				else if (CE)
					dly_q[gi] <= (gi == 0) ? s2_q : dly_q[(gi == 0) ? 0 : gi-1];
			end
		end
	endgenerate

	logic [11:0] data_s;
	logic        clk_c, clk_p, rise, fall, edge_hit;
	int          tap;
	// Code 1-7 samples earlier, 9-15 later; 0 and 8 sample at the centre tap
	always_comb
	begin
		tap = (deskew_q < vic_pkg::DESKEW_MID)
			? DLY_MAX + int'(deskew_q) * vic_pkg::STEP_CYC
			: DLY_MAX - int'(deskew_q - vic_pkg::DESKEW_MID) * vic_pkg::STEP_CYC;
		if (tap < 0) tap = 0;
		if (tap > DLY_MAX*2) tap = DLY_MAX*2;
		data_s = dly_q[tap][11:0];
		clk_c = dly_q[DLY_MAX][12];
		clk_p = dly_q[DLY_MAX+1][12];
		rise = clk_c && !clk_p; // True clock rising
		fall = !clk_c && clk_p;
		edge_hit = ddr_q ? (rise || fall) : (pol_q ? rise : fall);
	end

	// ************************************************************
	// Word pairing and format unpacking
	// ************************************************************
	logic        phase_q;
	logic [11:0] first_q;
	logic        hs_edge;
	logic        phase_eff;
	// Hsync taken at the clock tap, so the word on its edge is a first word
	assign hs_edge   = dly_q[DLY_MAX][13] && !dly_q[DLY_MAX+1][13];
	assign phase_eff = phase_q && !hs_edge;

	// Phase reset at hsync; DDR first word on chosen edge
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			phase_q <= 1'b0;
			first_q <= 12'h000;
			PIX_VLD <= 1'b0;
			PIX_DATA <= 24'h000000;
			count_q <= 16'h0000;
		end
		else if (CE)
		begin
			PIX_VLD <= 1'b0;
			if (hs_edge && !edge_hit)
				phase_q <= 1'b0;
			else if (edge_hit)
			begin
				if (!phase_eff && (!ddr_q || (pol_q ? rise : fall)))
				begin
					first_q <= data_s;
					phase_q <= 1'b1;
				end
				else if (phase_eff)
				begin
					phase_q <= 1'b0;
					PIX_VLD <= 1'b1;
					count_q <= count_q + 16'h0001;
					case (fmt_q) // PIX_DATA = {R, G, B} or {zero, Y, first}
						vic_pkg::FMT_RGB12_A: PIX_DATA <= {data_s[11:4],
							data_s[3:0], first_q[11:8], first_q[7:0]};
						vic_pkg::FMT_RGB12_B: PIX_DATA <= {data_s[11:7], data_s[3:1],
							data_s[6:4], first_q[11:9], data_s[0], first_q[3],
							first_q[8:4], first_q[2:0]};
						vic_pkg::FMT_RGB565: PIX_DATA <= {data_s[11:7], 3'h0,
							data_s[6:4], first_q[11:9], 2'h0, first_q[8:4], 3'h0};
						vic_pkg::FMT_RGB555: PIX_DATA <= {data_s[10:6], 3'h0,
							data_s[5:4], first_q[11:9], 3'h0, first_q[8:4], 3'h0};
						vic_pkg::FMT_YCRCB: PIX_DATA <= {8'h00, data_s[7:0],
							first_q[7:0]}; // Chroma then luma
						default: PIX_DATA <= 24'h000000;
					endcase
				end
				else
					phase_q <= 1'b0; // Hsync on the other edge
			end
		end
	end

	// ************************************************************
	// Embedded sync decode and register readback
	// ************************************************************
	logic dec_ref, dec_field, dec_vb, dec_eav;
	vic_sync_decode u_dec
	(
		.clk       (CLK),
		.rstn      (RSTN),
		.ce        (CE),
		.enable    (sync_en_q && fmt_q == vic_pkg::FMT_YCRCB),
		.word_vld  (edge_hit),
		.word      (data_s[7:0]),
		.ref_pulse (dec_ref),
		.field_q   (dec_field),
		.vblank_q  (dec_vb),
		.eav_q     (dec_eav)
	);

	// Read data registered in the address phase
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			HRDATA <= vic_pkg::RESET_VAL;
			REF_PULSE <= 1'b0;
		end
		else if (CE)
		begin
			REF_PULSE <= dec_ref;
			if (HSEL && HREADY && HTRANS[1] && !HWRITE)
			begin
				case (HADDR[7:0])
					vic_pkg::REG_CTRL:   HRDATA <= {25'h0, fmt_q, 2'h0, pol_q, ddr_q};
					vic_pkg::REG_DESKEW: HRDATA <= {28'h0, deskew_q};
					vic_pkg::REG_SYNC:   HRDATA <= {31'h0, sync_en_q};
					vic_pkg::REG_STATUS: HRDATA <= {25'h0, dec_field, dec_vb, dec_eav, 4'h0};
					vic_pkg::REG_PIXEL:  HRDATA <= {8'h00, PIX_DATA};
					vic_pkg::REG_COUNT:  HRDATA <= {16'h0000, count_q};
					default:             HRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : vic_capture

// file: rtl/vic_pkg.sv
// Package of constants for the video input capture link
package vic_pkg;
	// ************************************************************
	// Register map (controller side, AHB-Lite byte addresses)
	// ************************************************************
	localparam logic [7:0]  REG_CTRL       = 8'h00; // Mode, format, latch edge
	localparam logic [7:0]  REG_DESKEW     = 8'h74; // De-skew, index 1Dh times four
	localparam logic [7:0]  REG_SYNC       = 8'h7c; // Embedded sync enable, index 1Fh
	localparam logic [7:0]  REG_STATUS     = 8'h10; // Decoded flags
	localparam logic [7:0]  REG_PIXEL      = 8'h14; // Last pixel
	localparam logic [7:0]  REG_COUNT      = 8'h18; // Pixel count
	localparam logic [5:0]  DESKEW_IDX     = 6'h1d;
	localparam logic [5:0]  SYNC_IDX       = 6'h1f;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          CTRL_DDR_BIT   = 0;
	localparam int          CTRL_POL_BIT   = 1;
	localparam int          CTRL_FMT_LSB   = 4;
	localparam int          SYNC_EN_BIT    = 0;
	localparam int          ST_FIELD_BIT   = 6;
	localparam int          ST_VBLANK_BIT  = 5;
	localparam int          ST_EAV_BIT     = 4;
	localparam logic [3:0]  DESKEW_MID     = 4'h8;
	localparam logic [31:0] RESET_VAL      = 32'h0000_0000;
	// ************************************************************
	// Formats and timing
	// ************************************************************
	localparam logic [2:0]  FMT_RGB12_A    = 3'h0;
	localparam logic [2:0]  FMT_RGB12_B    = 3'h1;
	localparam logic [2:0]  FMT_RGB565     = 3'h2;
	localparam logic [2:0]  FMT_RGB555     = 3'h3;
	localparam logic [2:0]  FMT_YCRCB      = 3'h4;
	localparam int          STEP_NS        = 10;
	localparam int          CLK_NS         = 10;
	localparam int          STEP_CYC       = (STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          LINK_HALF_CYC  = 6; // Half period of generated link clock
endpackage : vic_pkg

// file: rtl/vic_link_if.sv
// Interface joining the source end and the capture end
`timescale 1ns/1ps
interface vic_link_if;
	logic        input_word_clock;
	logic        input_word_clock_n;
	logic [11:0] bus;
	logic        hsync;
	modport src (output input_word_clock, output input_word_clock_n, output bus, output hsync);
	modport cap (input input_word_clock, input input_word_clock_n, input bus, input hsync);
endinterface : vic_link_if

// file: rtl/vic_sync_decode.sv
// Embedded timing reference decoder for the YCrCb stream
`timescale 1ns/1ps
module vic_sync_decode
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic       enable,
	input  wire logic       word_vld,
	input  wire logic [7:0] word,
	output logic            ref_pulse,
	output logic            field_q,
	output logic            vblank_q,
	output logic            eav_q
);
	logic [1:0] hist_q;

	// Count the ones, zero, zero preamble
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hist_q <= 2'h0;
		else if (ce && word_vld)
		begin
			if (word == 8'hff)
				hist_q <= 2'h1;
			else if (word == 8'h00 && hist_q != 2'h0 && hist_q != 2'h3)
				hist_q <= hist_q + 2'h1;
			else
				hist_q <= 2'h0;
		end
	end

	// Status byte after preamble; bits 7 and 3:0 ignored
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ref_pulse <= 1'b0;
			field_q   <= 1'b0;
			vblank_q  <= 1'b0;
			eav_q     <= 1'b0;
		end
		else if (ce)
		begin
			ref_pulse <= 1'b0;
			if (enable && word_vld && hist_q == 2'h3)
			begin
				ref_pulse <= 1'b1;
				field_q   <= word[vic_pkg::ST_FIELD_BIT];
				vblank_q  <= word[vic_pkg::ST_VBLANK_BIT];
				eav_q     <= word[vic_pkg::ST_EAV_BIT];
			end
		end
	end
endmodule : vic_sync_decode

// file: rtl/vic_source.sv
// Source end: drives word clock, bus and horizontal sync
`timescale 1ns/1ps
module vic_source
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        CE,
	input  wire logic        DDR_MODE,
	input  wire logic        HSYNC_REQ,
	input  wire logic        WORD_VLD,
	input  wire logic [11:0] WORD,
	output logic             WORD_RDY,
	vic_link_if.src          link
);
	logic [3:0]  div_q;
	logic        clk_q;
	logic        hs_q;
	logic [11:0] bus_q;

	// Divider makes the word clock; each word is put on at a clock change
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			div_q    <= 4'h0;
			clk_q    <= 1'b0;
			hs_q     <= 1'b0;
			bus_q    <= 12'h000;
			WORD_RDY <= 1'b0;
		end
		else if (CE)
		begin
			WORD_RDY <= 1'b0;
			if (div_q == 4'(vic_pkg::LINK_HALF_CYC - 1))
			begin
				div_q <= 4'h0;
				clk_q <= ~clk_q;
				// Words change on falling edge in SDR, every edge in DDR
				if (DDR_MODE || clk_q)
				begin
					hs_q     <= HSYNC_REQ; // Pairs aligned after hsync
					bus_q    <= WORD_VLD ? WORD : 12'h000; // Idle blanking
					WORD_RDY <= WORD_VLD;
				end
			end
			else
				div_q <= div_q + 4'h1;
		end
	end

	assign link.input_word_clock   = clk_q;
	assign link.input_word_clock_n = ~clk_q;
	assign link.bus                = bus_q;
	assign link.hsync              = hs_q;
endmodule : vic_source

// file: verif/vic_link_checker.sv
// Checker on the link signals and capture outputs
`timescale 1ns/1ps
module vic_link_checker
(
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        input_word_clock,
	input wire logic        input_word_clock_n,
	input wire logic [11:0] bus,
	input wire logic        hsync,
	input wire logic        PIX_VLD,
	input wire logic [23:0] PIX_DATA,
	input wire logic        REF_PULSE,
	input wire logic        HREADYOUT,
	input wire logic        HRESP
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_rst_idle;
		$rose(RSTN) |-> !input_word_clock && !hsync && bus == 12'h000;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
	property p_clk_comp;
		input_word_clock_n == !input_word_clock;
	endproperty
	a_clk_comp: assert property (p_clk_comp) else $error("clock pair not complementary");
	property p_clk_half;
		$changed(input_word_clock) |=> $stable(input_word_clock) [*5];
	endproperty
	a_clk_half: assert property (p_clk_half) else $error("link half period short");
	property p_pix_gap;
		PIX_VLD |=> !PIX_VLD [*8];
	endproperty
	a_pix_gap: assert property (p_pix_gap) else $error("pixels closer than two words");
	property p_pix_hold;
		$changed(PIX_DATA) |-> PIX_VLD;
	endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel data moved without valid");
	property p_ref_gap;
		REF_PULSE |=> !REF_PULSE [*3];
	endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("reference pulses too close");
	property p_ready;
		HREADYOUT;
	endproperty
	a_ready: assert property (p_ready) else $error("bus wait inserted");
	property p_okay;
		!HRESP;
	endproperty
	a_okay: assert property (p_okay) else $error("bus response not okay");
endmodule : vic_link_checker

// file: verif/video_input_capture_demux_tb.sv
// Bench joining source and capture ends over the link
`timescale 1ns/1ps
module video_input_capture_demux_tb;
	logic        clk;
	logic        rstn;
	logic        ddr;
	logic        hs_req;
	logic        wvld;
	logic [11:0] wdat;
	logic        wrdy;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        pix_vld;
	logic [23:0] pix_data;
	logic        ref_pulse;
	logic [31:0] rd;
	logic [7:0]  dsk;
	logic [23:0] cap[$];
	int          nref;
	int          cyc;
	int          err_total;
	int          n_checks;
	vic_link_if link();
	vic_source u_vic_source (.CLK(clk), .RSTN(rstn), .CE(1'b1), .DDR_MODE(ddr),
		.HSYNC_REQ(hs_req), .WORD_VLD(wvld), .WORD(wdat), .WORD_RDY(wrdy), .link(link));
	vic_capture #(.DLY_MAX(8)) u_vic_capture (.CLK(clk), .RSTN(rstn), .CE(1'b1), .link(link),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.PIX_VLD(pix_vld), .PIX_DATA(pix_data), .REF_PULSE(ref_pulse));
	vic_link_checker u_vic_link_checker (.CLK(clk), .RSTN(rstn),
		.input_word_clock(link.input_word_clock), .input_word_clock_n(link.input_word_clock_n),
		.bus(link.bus), .hsync(link.hsync), .PIX_VLD(pix_vld), .PIX_DATA(pix_data),
		.REF_PULSE(ref_pulse), .HREADYOUT(hready), .HRESP(hresp));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// Single AHB transfer, waits on ready
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// One word to the source, held until taken
	task automatic put(input logic [11:0] w, input logic h);
		wvld <= 1'b1;
		wdat <= w;
		hs_req <= h;
		@(posedge clk); // Skip a ready pulse left from the word before
		do @(posedge clk); while (wrdy !== 1'b1);
	endtask : put
	// Expected pixel, first word, second word
	function automatic logic [47:0] enc(input logic [2:0] f, input logic [23:0] p, input logic j);
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		{r, g, b} = p;
		case (f)
			3'h0: enc = {r, g, b, g[3:0], b, r, g[7:4]};
			3'h1: enc = {r, g, b, g[4:2], b[7:3], g[0], b[2:0], r[7:3], g[7:5], r[2:0], g[1]};
			3'h2: enc = {r[7:3], 3'h0, g[7:2], 2'h0, b[7:3], 3'h0, g[4:2], b[7:3], 4'h0,
				r[7:3], g[7:5], 4'h0};
			3'h3: enc = {r[7:3], 3'h0, g[7:3], 3'h0, b[7:3], 3'h0, g[5:3], b[7:3], 4'h0,
				j, r[7:3], g[7:6], 4'h0};
			default: enc = {8'h0, g, b, 4'h0, b, 4'h0, g};
		endcase
	endfunction : enc
	// One line of six random pixels
	task automatic line(input logic [2:0] f, input logic d, input logic pol);
		logic [47:0] e[6];
		int j;
		ddr <= d;
		ahb(1'b1, vic_pkg::REG_CTRL, {25'h0, f, 2'h0, pol, d});
		cap.delete();
		// First word must go out on the chosen edge
		while (link.input_word_clock !== pol) @(posedge clk);
		while (link.input_word_clock !== ~pol) @(posedge clk);
		foreach (e[i])
		begin
			e[i] = enc(f, 24'($urandom), 1'($urandom));
			put(e[i][23:12], i == 0);
			put(e[i][11:0], 1'b0);
		end
		repeat (4) put(12'h0, 1'b0);
		repeat (30) @(posedge clk);
		j = -1;
		foreach (cap[i]) if (j < 0 && cap[i] === e[0][47:24]) j = i;
		foreach (e[i]) chk("pixel", cap[j + i], e[i][47:24]);
		ahb(1'b0, vic_pkg::REG_PIXEL, 32'h0);
		chk("pixel reg", rd, 32'h0);
		$display("line format %0d ddr %0d done", f, d);
	endtask : line
	// Embedded reference with given status
	task automatic sync(input logic en, input logic [7:0] s);
		ddr <= 1'b0;
		ahb(1'b1, vic_pkg::REG_SYNC, {31'h0, en});
		ahb(1'b1, vic_pkg::REG_CTRL, 32'h0000_0042);
		nref = 0;
		put(12'h0ff, 1'b1);
		put(12'h000, 1'b0);
		put(12'h000, 1'b0);
		put({4'h0, s}, 1'b0);
		repeat (4) put(12'h000, 1'b0);
		chk("refs", nref, {31'h0, en});
		ahb(1'b0, vic_pkg::REG_STATUS, 32'h0);
		if (en)
			chk("status", rd[6:4], s[6:4]);
		$display("sync enable %0d status %h done", en, s);
	endtask : sync
	// ****************************************
	// Clock, monitor, watchdog
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (pix_vld === 1'b1) cap.push_back(pix_data);
		if (ref_pulse === 1'b1) nref++;
		if (cyc == 40000)
		begin
			err_total++;
			end_of_test();
		end
	end
	// Main sequence
	initial
	begin
		{rstn, ddr, hs_req, wvld, wdat, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{nref, cyc, err_total, n_checks} = '0;
		rd = $urandom(32'hd88f);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		ahb(1'b0, vic_pkg::REG_CTRL, 32'h0);
		chk("ctrl reset", rd, vic_pkg::RESET_VAL);
		ahb(1'b0, vic_pkg::REG_DESKEW, 32'h0);
		chk("deskew reset", rd, {28'h0, vic_pkg::DESKEW_MID});
		ahb(1'b0, vic_pkg::REG_SYNC, 32'h0);
		chk("sync reset", rd, vic_pkg::RESET_VAL);
		repeat (4)
		begin
			dsk = 8'($urandom);
			ahb(1'b1, vic_pkg::REG_DESKEW, {24'h0, dsk});
			ahb(1'b0, vic_pkg::REG_DESKEW, 32'h0);
			chk("deskew rw", rd, {28'h0, dsk[3:0]});
		end
		ahb(1'b1, 8'h40, 32'hffff_ffff);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("register test done");
		ahb(1'b1, vic_pkg::REG_DESKEW, 32'h8);
		for (int f = 0; f < 5; f++) line(3'(f), 1'b0, 1'($urandom));
		ahb(1'b1, vic_pkg::REG_DESKEW, 32'h3);
		line(3'h0, 1'b0, 1'b1);
		ahb(1'b1, vic_pkg::REG_DESKEW, 32'h9);
		for (int f = 0; f < 5; f++) line(3'(f), 1'b1, 1'($urandom));
		// Status kept off ff, which would open a second preamble
		sync(1'b1, 8'($urandom) & 8'hfe);
		sync(1'b1, 8'($urandom) & 8'hfe);
		sync(1'b0, 8'($urandom) & 8'hfe);
		end_of_test();
	end
endmodule : video_input_capture_demux_tb
